//--- iudec_pkg.sv
// iudec_pkg.sv: shared constants, operation codes and carriers for the decoder
package iudec_pkg;

  // =====================================================================
  // opcode groups and fixed values
  localparam logic [3:0] GRP_4 = 4'h4;
  localparam logic [3:0] GRP_5 = 4'h5;
  localparam logic [3:0] GRP_6 = 4'h6;
  localparam logic [3:0] GRP_7 = 4'h7;
  localparam logic [3:0] GRP_8 = 4'h8;
  localparam logic [3:0] GRP_9 = 4'h9;
  localparam logic [3:0] GRP_A = 4'hA;
  localparam logic [3:0] GRP_B = 4'hB;
  localparam logic [3:0] GRP_C = 4'hC;
  localparam logic [3:0] GRP_D = 4'hD;
  localparam logic [3:0] GRP_E = 4'hE;
  localparam logic [31:0] RESET_VECTOR = 32'hA0000000;
  localparam int SR_MD_BIT = 30;
  localparam logic [31:0] SR_RESET = 32'h700000F0;
  localparam int SYNC_STAGES = 2;

  // =====================================================================
  // operation codes
  typedef enum logic [6:0] {
    IUD_UNDEF = 7'h00,
    IUD_SHIFT_LEFT_ONE = 7'h01,
    IUD_DECREMENT_AND_TEST = 7'h02,
    IUD_ARITH_SHIFT_LEFT_ONE = 7'h03,
    IUD_SHIFT_RIGHT_ONE = 7'h04,
    IUD_COMPARE_NONNEGATIVE = 7'h05,
    IUD_ARITH_SHIFT_RIGHT_ONE = 7'h06,
    IUD_STORE_SYS_REG_PREDEC = 7'h07,
    IUD_STORE_CTRL_REG_PREDEC = 7'h08,
    IUD_ROTATE_LEFT = 7'h09,
    IUD_ROTATE_LEFT_CARRY = 7'h0A,
    IUD_ROTATE_RIGHT = 7'h0B,
    IUD_COMPARE_POSITIVE = 7'h0C,
    IUD_ROTATE_RIGHT_CARRY = 7'h0D,
    IUD_LOAD_SYS_REG_POSTINC = 7'h0E,
    IUD_LOAD_CTRL_REG_POSTINC = 7'h0F,
    IUD_SHIFT_LEFT_TWO = 7'h10,
    IUD_SHIFT_LEFT_EIGHT = 7'h11,
    IUD_SHIFT_LEFT_SIXTEEN = 7'h12,
    IUD_SHIFT_RIGHT_TWO = 7'h13,
    IUD_SHIFT_RIGHT_EIGHT = 7'h14,
    IUD_SHIFT_RIGHT_SIXTEEN = 7'h15,
    IUD_COPY_TO_SYS_REG = 7'h16,
    IUD_JUMP_SUBROUTINE = 7'h17,
    IUD_TEST_AND_SET_BYTE = 7'h18,
    IUD_JUMP_REGISTER = 7'h19,
    IUD_DYNAMIC_ARITH_SHIFT = 7'h1A,
    IUD_DYNAMIC_LOGIC_SHIFT = 7'h1B,
    IUD_COPY_TO_CTRL_REG = 7'h1C,
    IUD_WORD_MULT_ACCUMULATE = 7'h1D,
    IUD_LOAD_DISP4_LONG = 7'h1E,
    IUD_LOAD_BYTE = 7'h1F,
    IUD_LOAD_WORD = 7'h20,
    IUD_LOAD_LONG = 7'h21,
    IUD_MOVE_REG = 7'h22,
    IUD_LOAD_BYTE_POSTINC = 7'h23,
    IUD_LOAD_WORD_POSTINC = 7'h24,
    IUD_LOAD_LONG_POSTINC = 7'h25,
    IUD_INVERT = 7'h26,
    IUD_SWAP_BYTE = 7'h27,
    IUD_SWAP_WORD = 7'h28,
    IUD_NEGATE_WITH_CARRY = 7'h29,
    IUD_NEGATE = 7'h2A,
    IUD_ZERO_EXTEND_BYTE = 7'h2B,
    IUD_ZERO_EXTEND_WORD = 7'h2C,
    IUD_SIGN_EXTEND_BYTE = 7'h2D,
    IUD_SIGN_EXTEND_WORD = 7'h2E,
    IUD_ADD_IMMEDIATE = 7'h2F,
    IUD_STORE_R0_DISP4_BYTE = 7'h30,
    IUD_STORE_R0_DISP4_WORD = 7'h31,
    IUD_LOAD_R0_DISP4_BYTE = 7'h32,
    IUD_LOAD_R0_DISP4_WORD = 7'h33,
    IUD_COMPARE_EQUAL = 7'h34,
    IUD_BRANCH_IF_TRUE = 7'h35,
    IUD_BRANCH_IF_FALSE = 7'h36,
    IUD_DELAYED_BRANCH_IF_TRUE = 7'h37,
    IUD_DELAYED_BRANCH_IF_FALSE = 7'h38,
    IUD_LOAD_PC_WORD = 7'h39,
    IUD_BRANCH_ALWAYS = 7'h3A,
    IUD_BRANCH_SUBROUTINE = 7'h3B,
    IUD_STORE_GBR_BYTE = 7'h3C,
    IUD_STORE_GBR_WORD = 7'h3D,
    IUD_STORE_GBR_LONG = 7'h3E,
    IUD_SOFTWARE_TRAP = 7'h3F,
    IUD_LOAD_GBR_BYTE = 7'h40,
    IUD_LOAD_GBR_WORD = 7'h41,
    IUD_LOAD_GBR_LONG = 7'h42,
    IUD_PC_RELATIVE_ADDRESS = 7'h43,
    IUD_TEST_IMMEDIATE = 7'h44,
    IUD_AND_IMMEDIATE = 7'h45,
    IUD_XOR_IMMEDIATE = 7'h46,
    IUD_OR_IMMEDIATE = 7'h47,
    IUD_TEST_IMMEDIATE_BYTE = 7'h48,
    IUD_AND_IMMEDIATE_BYTE = 7'h49,
    IUD_XOR_IMMEDIATE_BYTE = 7'h4A,
    IUD_OR_IMMEDIATE_BYTE = 7'h4B,
    IUD_LOAD_PC_LONG = 7'h4C,
    IUD_MOVE_IMMEDIATE = 7'h4D
  } iudec_op_t;

  // special register selectors: system, control and banked
  typedef enum logic [4:0] {
    IUD_SREG_NONE = 5'h00,
    IUD_SREG_MULT_HIGH = 5'h01,
    IUD_SREG_MULT_LOW = 5'h02,
    IUD_SREG_PROC_RET = 5'h03,
    IUD_SREG_STATUS = 5'h04,
    IUD_SREG_GLOBAL_BASE = 5'h05,
    IUD_SREG_VECTOR_BASE = 5'h06,
    IUD_SREG_SAVED_STATUS = 5'h07,
    IUD_SREG_SAVED_PC = 5'h08,
    IUD_SREG_BANK0 = 5'h10
  } iudec_sreg_t;

  // processor states, one-hot
  typedef enum logic [4:0] {
    IUD_ST_RESET = 5'b00001,
    IUD_ST_EXCEPTION = 5'b00010,
    IUD_ST_BUS_RELEASED = 5'b00100,
    IUD_ST_EXECUTE = 5'b01000,
    IUD_ST_POWER_DOWN = 5'b10000
  } iudec_state_t;

  // =====================================================================
  // decoded instruction carrier
  typedef struct packed {
    iudec_op_t op;
    logic [4:0] sreg;
    logic [3:0] rn;
    logic [3:0] rm;
    logic [31:0] imm;
    logic undefined;
    logic privileged;
  } iudec_dec_t;

endpackage

//--- iudec_sync.sv
// iudec_sync.sv: two-stage synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module iudec_sync
  import iudec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule // iudec_sync
`default_nettype wire

//--- iudec_table.sv
// iudec_table.sv: combinational opcode map for groups 0100 to 1110
`timescale 1ns/1ns
`default_nettype none
module iudec_table
  import iudec_pkg::*;
(
  input wire logic [15:0] instr_i,
  output iudec_dec_t dec_o
);
  logic [3:0] grp;
  logic [3:0] f2;
  logic [3:0] lo;
  logic [1:0] col;
  logic [1:0] pre;
  logic [4:0] ctl;

  assign grp = instr_i[15:12];
  assign f2 = instr_i[7:4];
  assign lo = instr_i[3:0];
  assign col = instr_i[5:4];
  assign pre = instr_i[7:6];

  // control selector shared by stores, loads and copies
  always_comb begin
    ctl = IUD_SREG_NONE;
    case (pre)
      2'b00: ctl = 5'(IUD_SREG_STATUS) + {3'h0, col};
      2'b01: ctl = (col == 2'b00) ? IUD_SREG_SAVED_PC : IUD_SREG_NONE;
      default: ctl = {2'b10, pre[0], col};
    endcase
  end

  always_comb begin
    dec_o = '0;
    dec_o.op = IUD_UNDEF;
    dec_o.rn = instr_i[11:8];
    dec_o.rm = instr_i[7:4];
    case (grp)
      GRP_4: begin
        dec_o.rm = instr_i[11:8];
        case (lo)
          4'h0: case (f2)
            4'h0: dec_o.op = IUD_SHIFT_LEFT_ONE; // [RQ1]
            4'h1: dec_o.op = IUD_DECREMENT_AND_TEST; // [RQ1]
            4'h2: dec_o.op = IUD_ARITH_SHIFT_LEFT_ONE; // [RQ1]
            default: dec_o.op = IUD_UNDEF;
          endcase
          4'h1: case (f2)
            4'h0: dec_o.op = IUD_SHIFT_RIGHT_ONE; // [RQ1]
            4'h1: dec_o.op = IUD_COMPARE_NONNEGATIVE; // [RQ1]
            4'h2: dec_o.op = IUD_ARITH_SHIFT_RIGHT_ONE; // [RQ1]
            default: dec_o.op = IUD_UNDEF;
          endcase
          4'h2, 4'h6, 4'hA: if (f2 < 4'h3) begin
            dec_o.sreg = 5'(IUD_SREG_MULT_HIGH) + {1'b0, f2}; // [RQ2] [RQ6]
            dec_o.op = (lo == 4'h2) ? IUD_STORE_SYS_REG_PREDEC :
              (lo == 4'h6) ? IUD_LOAD_SYS_REG_POSTINC :
              IUD_COPY_TO_SYS_REG; // [RQ10]
          end
          4'h3, 4'h7, 4'hE: if (ctl != IUD_SREG_NONE) begin
            dec_o.sreg = ctl; // [RQ3] [RQ4]
            dec_o.privileged = 1'b1;
            dec_o.op = (lo == 4'h3) ? IUD_STORE_CTRL_REG_PREDEC :
              (lo == 4'h7) ? IUD_LOAD_CTRL_REG_POSTINC :
              IUD_COPY_TO_CTRL_REG; // [RQ6] [RQ10]
          end
          4'h4: case (f2)
            4'h0: dec_o.op = IUD_ROTATE_LEFT; // [RQ5]
            4'h2: dec_o.op = IUD_ROTATE_LEFT_CARRY; // [RQ5]
            default: dec_o.op = IUD_UNDEF;
          endcase
          4'h5: case (f2)
            4'h0: dec_o.op = IUD_ROTATE_RIGHT; // [RQ5]
            4'h1: dec_o.op = IUD_COMPARE_POSITIVE; // [RQ5]
            4'h2: dec_o.op = IUD_ROTATE_RIGHT_CARRY; // [RQ5]
            default: dec_o.op = IUD_UNDEF;
          endcase
          4'h8: case (f2)
            4'h0: dec_o.op = IUD_SHIFT_LEFT_TWO; // [RQ7]
            4'h1: dec_o.op = IUD_SHIFT_LEFT_EIGHT; // [RQ7]
            4'h2: dec_o.op = IUD_SHIFT_LEFT_SIXTEEN; // [RQ7]
            default: dec_o.op = IUD_UNDEF;
          endcase
          4'h9: case (f2)
            4'h0: dec_o.op = IUD_SHIFT_RIGHT_TWO; // [RQ7]
            4'h1: dec_o.op = IUD_SHIFT_RIGHT_EIGHT; // [RQ7]
            4'h2: dec_o.op = IUD_SHIFT_RIGHT_SIXTEEN; // [RQ7]
            default: dec_o.op = IUD_UNDEF;
          endcase
          4'hB: case (f2)
            4'h0: dec_o.op = IUD_JUMP_SUBROUTINE; // [RQ8]
            4'h1: dec_o.op = IUD_TEST_AND_SET_BYTE; // [RQ8]
            4'h2: dec_o.op = IUD_JUMP_REGISTER; // [RQ8]
            default: dec_o.op = IUD_UNDEF;
          endcase
          4'hC: begin
            dec_o.op = IUD_DYNAMIC_ARITH_SHIFT; // [RQ9]
            dec_o.rm = instr_i[7:4];
          end
          4'hD: begin
            dec_o.op = IUD_DYNAMIC_LOGIC_SHIFT; // [RQ9]
            dec_o.rm = instr_i[7:4];
          end
          4'hF: begin
            dec_o.op = IUD_WORD_MULT_ACCUMULATE; // [RQ9]
            dec_o.rm = instr_i[7:4];
          end
          default: dec_o.op = IUD_UNDEF;
        endcase
      end
      GRP_5: begin
        dec_o.op = IUD_LOAD_DISP4_LONG; // [RQ12]
        dec_o.imm = {26'h0, lo, 2'b00};
      end
      GRP_6: begin
        case ({lo[3:2], lo[1:0]})
          4'h0: dec_o.op = IUD_LOAD_BYTE; // [RQ11]
          4'h1: dec_o.op = IUD_LOAD_WORD;
          4'h2: dec_o.op = IUD_LOAD_LONG;
          4'h3: dec_o.op = IUD_MOVE_REG;
          4'h4: dec_o.op = IUD_LOAD_BYTE_POSTINC;
          4'h5: dec_o.op = IUD_LOAD_WORD_POSTINC;
          4'h6: dec_o.op = IUD_LOAD_LONG_POSTINC;
          4'h7: dec_o.op = IUD_INVERT;
          4'h8: dec_o.op = IUD_SWAP_BYTE;
          4'h9: dec_o.op = IUD_SWAP_WORD;
          4'hA: dec_o.op = IUD_NEGATE_WITH_CARRY;
          4'hB: dec_o.op = IUD_NEGATE;
          4'hC: dec_o.op = IUD_ZERO_EXTEND_BYTE;
          4'hD: dec_o.op = IUD_ZERO_EXTEND_WORD;
          4'hE: dec_o.op = IUD_SIGN_EXTEND_BYTE;
          default: dec_o.op = IUD_SIGN_EXTEND_WORD;
        endcase
      end
      GRP_7: begin
        dec_o.op = IUD_ADD_IMMEDIATE; // [RQ12]
        dec_o.imm = {{24{instr_i[7]}}, instr_i[7:0]};
      end
      GRP_8: begin
        dec_o.rn = instr_i[7:4];
        dec_o.rm = instr_i[7:4];
        case (instr_i[11:8])
          4'h0: dec_o.op = IUD_STORE_R0_DISP4_BYTE; // [RQ13]
          4'h1: dec_o.op = IUD_STORE_R0_DISP4_WORD;
          4'h4: dec_o.op = IUD_LOAD_R0_DISP4_BYTE;
          4'h5: dec_o.op = IUD_LOAD_R0_DISP4_WORD;
          4'h8: dec_o.op = IUD_COMPARE_EQUAL;
          4'h9: dec_o.op = IUD_BRANCH_IF_TRUE;
          4'hB: dec_o.op = IUD_BRANCH_IF_FALSE;
          4'hD: dec_o.op = IUD_DELAYED_BRANCH_IF_TRUE;
          4'hF: dec_o.op = IUD_DELAYED_BRANCH_IF_FALSE;
          default: dec_o.op = IUD_UNDEF;
        endcase
        if (instr_i[11]) begin
          dec_o.imm = {{24{instr_i[7]}}, instr_i[7:0]};
        end else begin
          dec_o.imm = instr_i[8] ? {27'h0, lo, 1'b0} : {28'h0, lo};
        end
      end
      GRP_9, GRP_D: begin
        dec_o.op = (grp == GRP_9) ? IUD_LOAD_PC_WORD : IUD_LOAD_PC_LONG; // [RQ17]
        dec_o.imm = (grp == GRP_9) ? {23'h0, instr_i[7:0], 1'b0} :
          {22'h0, instr_i[7:0], 2'b00};
      end
      GRP_A, GRP_B: begin
        dec_o.op = (grp == GRP_A) ? IUD_BRANCH_ALWAYS : IUD_BRANCH_SUBROUTINE; // [RQ14]
        dec_o.imm = {{19{instr_i[11]}}, instr_i[11:0], 1'b0};
      end
      GRP_C: begin
        dec_o.imm = {24'h0, instr_i[7:0]};
        case (instr_i[11:8])
          4'h0: dec_o.op = IUD_STORE_GBR_BYTE; // [RQ15]
          4'h1: dec_o.op = IUD_STORE_GBR_WORD;
          4'h2: dec_o.op = IUD_STORE_GBR_LONG;
          4'h3: dec_o.op = IUD_SOFTWARE_TRAP;
          4'h4: dec_o.op = IUD_LOAD_GBR_BYTE;
          4'h5: dec_o.op = IUD_LOAD_GBR_WORD;
          4'h6: dec_o.op = IUD_LOAD_GBR_LONG;
          4'h7: dec_o.op = IUD_PC_RELATIVE_ADDRESS;
          4'h8: dec_o.op = IUD_TEST_IMMEDIATE; // [RQ16]
          4'h9: dec_o.op = IUD_AND_IMMEDIATE;
          4'hA: dec_o.op = IUD_XOR_IMMEDIATE;
          4'hB: dec_o.op = IUD_OR_IMMEDIATE;
          4'hC: dec_o.op = IUD_TEST_IMMEDIATE_BYTE;
          4'hD: dec_o.op = IUD_AND_IMMEDIATE_BYTE;
          4'hE: dec_o.op = IUD_XOR_IMMEDIATE_BYTE;
          default: dec_o.op = IUD_OR_IMMEDIATE_BYTE;
        endcase
      end
      GRP_E: begin
        dec_o.op = IUD_MOVE_IMMEDIATE; // [RQ12]
        dec_o.imm = {{24{instr_i[7]}}, instr_i[7:0]};
      end
      default: dec_o.op = IUD_UNDEF;
    endcase
    dec_o.undefined = (dec_o.op == IUD_UNDEF); // [RQ23]
  end
endmodule // iudec_table
`default_nettype wire

//--- iudec_top.sv
// iudec_top.sv: upper-group instruction decoder with processor state control
// Summary of operation
// RQ1: group4 nibble 0/1 shifts, decrement, compares
// RQ2: store mult/proc registers to predecremented Rn
// RQ3: store status/base/saved registers, saved PC
// RQ4: store banked registers zero to seven
// RQ5: rotates and compare positive
// RQ6: load special registers with Rm postincrement
// RQ7: fixed shifts by 2, 8, 16
// RQ8: jump subroutine, test-and-set, jump
// RQ9: dynamic shifts and word multiply accumulate
// RQ10: copy Rm into special registers
// RQ11: group6 loads, moves, swaps, negates, extends
// RQ12: add immediate, move immediate, disp load
// RQ13: group8 moves, compare, conditional branches
// RQ14: branch and branch subroutine, 12-bit displacement
// RQ15: global-base stores, trap, loads, PC address
// RQ16: immediate logic ops on R0 or byte
// RQ17: PC-relative word and long loads
// RQ18: power-on and manual reset entry
// RQ19: fetch from fixed reset vector after reset
// RQ20: exception saves PC and status, vectors
// RQ21: mode bit set on entry, cleared on exit
// RQ22: five processor states
// RQ23: unassigned opcodes flagged undefined
`timescale 1ns/1ns
`default_nettype none
module iudec_top
  import iudec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic power_on_reset_n_i,
  input wire logic manual_reset_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [31:0] pc_i,
  input wire logic exception_i,
  input wire logic [31:0] vector_offset_i,
  input wire logic [31:0] vector_base_i,
  input wire logic exception_done_i,
  input wire logic bus_request_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  output logic dec_valid_o,
  output iudec_dec_t dec_o,
  output logic [31:0] fetch_addr_o,
  output logic fetch_load_o,
  output logic [31:0] saved_pc_o,
  output logic [31:0] saved_status_o,
  output logic [31:0] status_o,
  output logic user_mode_o,
  output logic privilege_fault_o,
  output logic [4:0] state_o,
  output logic bus_controller_reset_o,
  output logic module_reset_o
);
  // =====================================================================
  // reset pin synchronisers
  logic por_n_sync;
  logic man_n_sync;
  iudec_dec_t dec_comb;
  iudec_state_t state_reg;
  iudec_state_t state_next;
  logic reset_any;
  logic reset_prev_reg;
  logic exc_take;

  iudec_sync u_sync_por (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .async_i(power_on_reset_n_i),
    .sync_o(por_n_sync)
  );

  iudec_sync u_sync_man (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .async_i(manual_reset_n_i),
    .sync_o(man_n_sync)
  );

  assign reset_any = !por_n_sync || !man_n_sync;

  // a wake-up interrupt takes the same save and redirect path
  assign exc_take = !reset_any && exception_i &&
    (state_reg == IUD_ST_EXECUTE || state_reg == IUD_ST_POWER_DOWN);

  // =====================================================================
  // opcode table
  iudec_table u_table (
    .instr_i(instr_i),
    .dec_o(dec_comb)
  );

  // decoded word is registered so outputs come straight from flops
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dec_valid_o <= 1'b0;
      dec_o <= '0;
    end else if (reset_any) begin
      dec_valid_o <= 1'b0;
      dec_o <= '0;
    end else begin
      dec_valid_o <= instr_valid_i && (state_reg == IUD_ST_EXECUTE);
      dec_o <= dec_comb; // [RQ23]
    end
  end

  // privileged-only encodings in user mode are reported, not decoded away
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      privilege_fault_o <= 1'b0;
    end else begin
      privilege_fault_o <= !reset_any && instr_valid_i &&
        (state_reg == IUD_ST_EXECUTE) && dec_comb.privileged &&
        !status_o[SR_MD_BIT]; // [RQ21]
    end
  end

  // =====================================================================
  // processor state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IUD_ST_RESET: state_next = IUD_ST_EXCEPTION; // [RQ19]
      IUD_ST_EXCEPTION: if (exception_done_i) begin
        state_next = IUD_ST_EXECUTE;
      end
      IUD_ST_EXECUTE: begin
        if (exception_i) begin
          state_next = IUD_ST_EXCEPTION; // [RQ20]
        end else if (bus_request_i) begin
          state_next = IUD_ST_BUS_RELEASED;
        end else if (sleep_i) begin
          state_next = IUD_ST_POWER_DOWN;
        end
      end
      IUD_ST_BUS_RELEASED: if (!bus_request_i) begin
        state_next = IUD_ST_EXECUTE;
      end
      IUD_ST_POWER_DOWN: if (wake_i || exception_i) begin
        state_next = exception_i ? IUD_ST_EXCEPTION : IUD_ST_EXECUTE;
      end
      default: state_next = IUD_ST_RESET;
    endcase
    if (reset_any) begin
      state_next = IUD_ST_RESET; // [RQ18]
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= IUD_ST_RESET;
      state_o <= IUD_ST_RESET;
    end else begin
      state_reg <= state_next; // [RQ22]
      state_o <= state_next;
    end
  end

  // =====================================================================
  // reset scopes: manual reset leaves the bus controller alone
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_controller_reset_o <= 1'b1;
      module_reset_o <= 1'b1;
    end else begin
      bus_controller_reset_o <= !por_n_sync; // [RQ18]
      module_reset_o <= reset_any; // [RQ18]
    end
  end

  // =====================================================================
  // fetch redirection, status and saved copies
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reset_prev_reg <= 1'b1;
    end else begin
      reset_prev_reg <= reset_any;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fetch_addr_o <= RESET_VECTOR;
      fetch_load_o <= 1'b0;
    end else if (reset_prev_reg && !reset_any) begin
      fetch_addr_o <= RESET_VECTOR; // [RQ19]
      fetch_load_o <= 1'b1;
    end else if (exc_take) begin
      fetch_addr_o <= vector_base_i + vector_offset_i; // [RQ20]
      fetch_load_o <= 1'b1;
    end else begin
      fetch_load_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      saved_pc_o <= '0;
      saved_status_o <= '0;
    end else if (exc_take) begin
      saved_pc_o <= pc_i; // [RQ20]
      saved_status_o <= status_o; // [RQ20]
    end
  end

  // mode bit: entry sets it, exit drops to user mode
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_o <= SR_RESET;
      user_mode_o <= 1'b0;
    end else if (reset_any) begin
      status_o <= SR_RESET; // [RQ21]
      user_mode_o <= 1'b0;
    end else if (exc_take) begin
      status_o[SR_MD_BIT] <= 1'b1; // [RQ21]
      user_mode_o <= 1'b0;
    end else if (state_reg == IUD_ST_EXCEPTION && exception_done_i) begin
      status_o[SR_MD_BIT] <= 1'b0; // [RQ21]
      user_mode_o <= 1'b1;
    end
  end

  // =====================================================================
  // checks
  sequence s_exc_taken;
    exc_take;
  endsequence

  AST_RESET_STATE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    reset_any |=> state_reg == IUD_ST_RESET) // [RQ18]
    else $error("reset not entered");
  AST_BSC_KEPT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (por_n_sync && !man_n_sync) |=> module_reset_o && !bus_controller_reset_o) // [RQ18]
    else $error("manual reset hit bus controller");
  AST_VECTOR: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (reset_prev_reg && !reset_any) |=> fetch_load_o && fetch_addr_o == RESET_VECTOR) // [RQ19]
    else $error("reset vector wrong");
  AST_SAVE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_exc_taken |=> saved_pc_o == $past(pc_i) && saved_status_o == $past(status_o)) // [RQ20]
    else $error("exception save wrong");
  AST_MD_SET: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_exc_taken |=> status_o[SR_MD_BIT] && state_reg == IUD_ST_EXCEPTION) // [RQ21]
    else $error("mode bit not set");
  AST_MD_CLR: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (state_reg == IUD_ST_EXCEPTION && exception_done_i && !reset_any)
    |=> !status_o[SR_MD_BIT] && user_mode_o) // [RQ21]
    else $error("mode bit not cleared");
  AST_ONEHOT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $onehot(state_reg)) // [RQ22]
    else $error("state not one-hot");
  AST_UNDEF: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (instr_i[15:12] == 4'hF && !reset_any) |=> dec_o.undefined) // [RQ23]
    else $error("group 15 not undefined");
  AST_BRANCH: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (instr_i[15:12] == GRP_A && !reset_any) |=> dec_o.op == IUD_BRANCH_ALWAYS) // [RQ14]
    else $error("branch not decoded");
endmodule // iudec_top
`default_nettype wire

//--- testbench.sv
// testbench.sv: self-checking bench for the upper-group decoder
`timescale 1ns/1ns
`default_nettype none
module testbench
  import iudec_pkg::*;
;
  // =====================================================================
  // signals
  logic clk_sys_i, nrst_i, por_n, man_n, vld, exc, done, breq, slp, wk;
  logic [15:0] instr;
  logic [31:0] pc, voff, vbase, fa, saved_program_counter, saved_status_reg, sr;
  logic dv, fl, um, pf, bcr, mr;
  logic [4:0] st;
  iudec_dec_t dec;
  int n_fail, n_tests;
  iudec_top u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .power_on_reset_n_i(por_n), .manual_reset_n_i(man_n),
    .instr_valid_i(vld), .instr_i(instr), .pc_i(pc), .exception_i(exc),
    .vector_offset_i(voff), .vector_base_i(vbase),
    .exception_done_i(done), .bus_request_i(breq), .sleep_i(slp),
    .wake_i(wk), .dec_valid_o(dv), .dec_o(dec), .fetch_addr_o(fa),
    .fetch_load_o(fl), .saved_pc_o(saved_program_counter), .saved_status_o(saved_status_reg),
    .status_o(sr), .user_mode_o(um), .privilege_fault_o(pf),
    .state_o(st), .bus_controller_reset_o(bcr), .module_reset_o(mr));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // =====================================================================
  // helpers
  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // bounded wait for the redirect pulse
  task automatic wl();
    for (int i = 0; i < 20 && fl !== 1'b1; i++) cyc(1);
    if (fl !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic fin();
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(1);
    chk("state", st, IUD_ST_EXECUTE);
    chk("user", um, 1'b1);
    chk("md", sr[SR_MD_BIT], 1'b0);
  endtask
  task automatic dc(input logic [15:0] w, input iudec_op_t op);
    instr = w;
    vld = 1'b1;
    cyc(1);
    chk("op", dec.op, op);
    chk("valid", dv, 1'b1);
  endtask
  // =====================================================================
  // scenarios
  task automatic pin_rst(input logic pon);
    if (pon) por_n = 1'b0;
    else man_n = 1'b0;
    cyc(5);
    chk("rst state", st, IUD_ST_RESET);
    chk("mod rst", mr, 1'b1);
    chk("bsc rst", bcr, pon);
    por_n = 1'b1;
    man_n = 1'b1;
    wl();
    chk("vector", fa, RESET_VECTOR);
    chk("md set", sr[SR_MD_BIT], 1'b1);
    fin();
  endtask
  task automatic decode_all();
    dc(16'h4000, IUD_SHIFT_LEFT_ONE);
    dc(16'h4011, IUD_COMPARE_NONNEGATIVE);
    dc(16'h4222, IUD_STORE_SYS_REG_PREDEC);
    chk("sreg", dec.sreg, IUD_SREG_PROC_RET);
    dc(16'h41F3, IUD_STORE_CTRL_REG_PREDEC);
    chk("bank", dec.sreg, 5'h17);
    dc(16'h4143, IUD_STORE_CTRL_REG_PREDEC);
    chk("spc sel", dec.sreg, IUD_SREG_SAVED_PC);
    dc(16'h4125, IUD_ROTATE_RIGHT_CARRY);
    dc(16'h4114, IUD_UNDEF);
    chk("undef", dec.undefined, 1'b1);
    dc(16'h4307, IUD_LOAD_CTRL_REG_POSTINC);
    dc(16'h4118, IUD_SHIFT_LEFT_EIGHT);
    dc(16'h4229, IUD_SHIFT_RIGHT_SIXTEEN);
    dc(16'h411B, IUD_TEST_AND_SET_BYTE);
    dc(16'h412D, IUD_DYNAMIC_LOGIC_SHIFT);
    dc(16'h412F, IUD_WORD_MULT_ACCUMULATE);
    dc(16'h412A, IUD_COPY_TO_SYS_REG);
    dc(16'h410E, IUD_COPY_TO_CTRL_REG);
    chk("priv", pf, 1'b1);
    dc(16'h612A, IUD_NEGATE_WITH_CARRY);
    dc(16'h612F, IUD_SIGN_EXTEND_WORD);
    dc(16'h7180, IUD_ADD_IMMEDIATE);
    chk("imm", dec.imm, 32'hFFFFFF80);
    dc(16'h5123, IUD_LOAD_DISP4_LONG);
    dc(16'h8F10, IUD_DELAYED_BRANCH_IF_FALSE);
    dc(16'h8810, IUD_COMPARE_EQUAL);
    dc(16'hA123, IUD_BRANCH_ALWAYS);
    chk("disp", dec.imm, 32'h00000246);
    dc(16'hBFFF, IUD_BRANCH_SUBROUTINE);
    dc(16'hC3FF, IUD_SOFTWARE_TRAP);
    dc(16'hC710, IUD_PC_RELATIVE_ADDRESS);
    dc(16'hCF01, IUD_OR_IMMEDIATE_BYTE);
    dc(16'h9105, IUD_LOAD_PC_WORD);
    dc(16'hD105, IUD_LOAD_PC_LONG);
    dc(16'hF123, IUD_UNDEF);
    vld = 1'b0;
  endtask
  task automatic excp();
    pc = 32'h0C001234;
    vbase = 32'h8C000000;
    voff = 32'h00000600;
    exc = 1'b1;
    cyc(1);
    exc = 1'b0;
    wl();
    chk("target", fa, 32'h8C000600);
    chk("spc", saved_program_counter, 32'h0C001234);
    chk("ssr", saved_status_reg, SR_RESET & ~32'h40000000);
    chk("md", sr[SR_MD_BIT], 1'b1);
    chk("state", st, IUD_ST_EXCEPTION);
    fin();
  endtask
  task automatic states();
    breq = 1'b1;
    cyc(2);
    chk("bus", st, IUD_ST_BUS_RELEASED);
    breq = 1'b0;
    cyc(2);
    chk("run", st, IUD_ST_EXECUTE);
    slp = 1'b1;
    cyc(1);
    slp = 1'b0;
    cyc(1);
    chk("sleep", st, IUD_ST_POWER_DOWN);
    wk = 1'b1;
    cyc(1);
    wk = 1'b0;
    cyc(1);
    chk("wake", st, IUD_ST_EXECUTE);
    slp = 1'b1;
    cyc(1);
    slp = 1'b0;
    exc = 1'b1;
    cyc(1);
    exc = 1'b0;
    chk("pd exc", st, IUD_ST_EXCEPTION);
    chk("pd md", sr[SR_MD_BIT], 1'b1);
    chk("pd load", fl, 1'b1);
    fin();
  endtask
  // =====================================================================
  // main sequence
  initial begin
    {nrst_i, vld, exc, done, breq, slp, wk} = '0;
    {por_n, man_n} = 2'b11;
    {instr, pc, voff, vbase} = '0;
    n_fail = 0;
    n_tests = 0;
    cyc(20);
    nrst_i = 1'b1;
    wl();
    chk("vector", fa, RESET_VECTOR);
    fin();
    decode_all();
    excp();
    states();
    pin_rst(1'b0);
    pin_rst(1'b1);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
